// [design/st3_pkg.sv]
// Function
// [R1] high-byte overflow flag sets when the upper count byte wraps FF to 00
// [R2] in 16-bit operation that flag sets when the full count wraps FFFF to 0
// [R3] set high-byte flag requests an interrupt while the timer interrupt is on
// [R4] overflow flags never clear by hardware; software clears them by writing
// [R5] low-byte overflow flag sets on every low byte wrap, any mode
// [R6] low-byte irq enable plus timer interrupt enable: low wrap requests irq
// [R7] capture enable bit: 0 turns capture off, 1 turns it on
// [R8] split select: 0 one 16-bit reload counter, 1 two 8-bit reload counters
// [R9] run bit starts counting; in split mode it gates only the upper byte
// [R10] control bit 1 reads zero and ignores writes
// [R11] external select: 0 system clock over 12, 1 external clock over 8
// [R12] in split mode external select serves both bytes, byte selects override
// [R13] byte clock select 1 picks undivided system clock, 0 defers to ext select
// [R14] on a 16-bit wrap the 16-bit reload value loads into the count
// [R15] capture: falling edge of ext/8 copies count into reload, sets high flag
// [R16] software writing 1 to an overflow flag sets it like a hardware overflow
package st3_pkg;

    // =========================================================
    // register addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h91;
    localparam logic [7:0] ADDR_RLD_LO = 8'h92;
    localparam logic [7:0] ADDR_RLD_HI = 8'h93;
    localparam logic [7:0] ADDR_CNT_LO = 8'h94;
    localparam logic [7:0] ADDR_CNT_HI = 8'h95;

    // =========================================================
    // control field positions and reset values
    localparam int         BIT_HOVF    = 7;
    localparam int         BIT_LOVF    = 6;
    localparam int         BIT_LIRQ_EN = 5;
    localparam int         BIT_CAP_EN  = 4;
    localparam int         BIT_SPLIT   = 3;
    localparam int         BIT_RUN     = 2;
    localparam int         BIT_UNUSED  = 1;
    localparam int         BIT_XCLK    = 0;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET  = 8'h00;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;

    // =========================================================
    // count limits and divider counts
    localparam logic [7:0]  BYTE_MAX      = 8'hFF;
    localparam logic [15:0] WORD_MAX      = 16'hFFFF;
    localparam int          SYS_DIV       = 12;
    localparam int          EXT_DIV       = 8;
    localparam logic [3:0]  SYS_DIV_LAST  = 4'(SYS_DIV - 1);
    localparam logic [2:0]  EXT_DIV_LAST  = 3'(EXT_DIV - 1);
    localparam logic [2:0]  EXT_DIV_HALF  = 3'(EXT_DIV / 2);

    // =========================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } st3_sfr_req_s;

    typedef struct packed {
        logic hovf;
        logic lovf;
        logic lirq_en;
        logic cap_en;
        logic split;
        logic run;
        logic unused;
        logic xclk;
    } st3_ctrl_s;

    typedef struct packed {
        logic div12;
        logic ext8;
        logic capture;
    } st3_tick_s;

endpackage : st3_pkg

// [design/st3_tick_gen.sv]
module st3_tick_gen (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // external oscillator, already synchronous
    input  wire logic          ext_osc,
    // timebase pulses
    output st3_pkg::st3_tick_s ticks
);

    // =========================================================
    // state
    typedef struct packed {
        logic [3:0]         sys_cnt;
        logic [2:0]         ext_cnt;
        logic               ext_q;
        st3_pkg::st3_tick_s tick;
    } st3_tick_state_s;

    st3_tick_state_s s_r;
    st3_tick_state_s s_nxt;

    // =========================================================
    // dividers
    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = '0;
        s_nxt.ext_q = ext_osc;
        if (s_r.sys_cnt == st3_pkg::SYS_DIV_LAST) begin
            s_nxt.sys_cnt    = 4'h0;
            s_nxt.tick.div12 = 1'b1; // [R11]
        end else begin
            s_nxt.sys_cnt = s_r.sys_cnt + 4'h1;
        end
        // count rising edges; one tick on every eighth edge, as the counter wraps from 7
        if (ext_osc && !s_r.ext_q) begin
            s_nxt.ext_cnt = s_r.ext_cnt + 3'h1;
            if (s_r.ext_cnt == st3_pkg::EXT_DIV_LAST) begin
                s_nxt.tick.ext8    = 1'b1; // [R11]
                s_nxt.tick.capture = 1'b1; // [R15]
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ticks = s_r.tick;

endmodule : st3_tick_gen

// [design/st3_timer.sv]
module st3_timer (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            resetn,
    // special function register port
    input  st3_pkg::st3_sfr_req_s sfr_req,
    output logic [7:0]           sfr_rdata,
    // clock control bits and interrupt enable from outside
    input  wire logic            high_byte_clock_select,
    input  wire logic            low_byte_clock_select,
    input  wire logic            timer_irq_enable,
    // external oscillator
    input  wire logic            ext_osc,
    // status toward the system
    output logic                 irq_req,
    output logic [15:0]          count_value
);

    // =========================================================
    // state
    typedef struct packed {
        st3_pkg::st3_ctrl_s ctrl;
        logic [7:0]         count_high_byte;
        logic [7:0]         count_low_byte;
        logic [7:0]         reload_high_byte;
        logic [7:0]         reload_low_byte;
        logic [7:0]         rdata;
        logic               irq;
    } st3_state_s;

    st3_state_s         s_r;
    st3_state_s         s_nxt;
    st3_pkg::st3_tick_s ticks;

    // =========================================================
    // timebase
    st3_tick_gen u_tick (
        .clk    (clk),
        .resetn (resetn),
        .ext_osc(ext_osc),
        .ticks  (ticks)
    );

    // =========================================================
    // helpers
    function automatic logic pick_tick(
        input logic               byte_sel,
        input logic               xclk,
        input st3_pkg::st3_tick_s t
    );
        logic r;
        r = 1'b0;
        if (byte_sel) begin
            r = 1'b1; // [R13]
        end else if (xclk) begin
            r = t.ext8; // [R11]
        end else begin
            r = t.div12; // [R11]
        end
        return r;
    endfunction : pick_tick

    function automatic logic is_max(input logic [7:0] v);
        return v == st3_pkg::BYTE_MAX;
    endfunction : is_max

    function automatic logic sel_hit(
        input st3_pkg::st3_sfr_req_s req,
        input logic [7:0]           addr
    );
        return req.wr && (req.addr == addr);
    endfunction : sel_hit

    // =========================================================
    // next state
    logic tick_lo;
    logic tick_hi;
    logic set_hovf;
    logic set_lovf;
    logic [15:0] word;

    always_comb begin
        s_nxt    = s_r;
        set_hovf = 1'b0;
        set_lovf = 1'b0;
        word     = {s_r.count_high_byte, s_r.count_low_byte};
        // low byte clock also drives the 16-bit counter
        tick_lo  = pick_tick(low_byte_clock_select, s_r.ctrl.xclk,
                             ticks); // [R12]
        tick_hi  = pick_tick(high_byte_clock_select, s_r.ctrl.xclk,
                             ticks); // [R12]

        if (!s_r.ctrl.split) begin
            // one 16-bit reload counter
            if (s_r.ctrl.run && tick_lo) begin // [R8] [R9]
                if (word == st3_pkg::WORD_MAX) begin
                    s_nxt.count_high_byte = s_r.reload_high_byte; // [R14]
                    s_nxt.count_low_byte  = s_r.reload_low_byte; // [R14]
                    set_hovf              = 1'b1; // [R2]
                end else begin
                    word                  = word + 16'h0001;
                    s_nxt.count_high_byte = word[15:8];
                    s_nxt.count_low_byte  = word[7:0];
                end
                if (is_max(s_r.count_low_byte)) begin
                    set_lovf = 1'b1; // [R5]
                end
            end
        end else begin
            // two 8-bit reload counters; low byte always runs
            if (tick_lo) begin // [R8] [R9]
                if (is_max(s_r.count_low_byte)) begin
                    s_nxt.count_low_byte = s_r.reload_low_byte;
                    set_lovf             = 1'b1; // [R5]
                end else begin
                    s_nxt.count_low_byte = s_r.count_low_byte + 8'h01;
                end
            end
            if (s_r.ctrl.run && tick_hi) begin // [R9]
                if (is_max(s_r.count_high_byte)) begin
                    s_nxt.count_high_byte = s_r.reload_high_byte;
                    set_hovf              = 1'b1; // [R1]
                end else begin
                    s_nxt.count_high_byte = s_r.count_high_byte + 8'h01;
                end
            end
        end

        // capture of the running count; takes the reload slot this cycle
        if (s_r.ctrl.cap_en && ticks.capture) begin // [R7]
            s_nxt.reload_high_byte = s_r.count_high_byte; // [R15]
            s_nxt.reload_low_byte  = s_r.count_low_byte; // [R15]
            set_hovf               = 1'b1; // [R15]
        end

        // software writes win over counting on data bytes
        if (sel_hit(sfr_req, st3_pkg::ADDR_RLD_LO)) begin
            s_nxt.reload_low_byte = sfr_req.wdata;
        end
        if (sel_hit(sfr_req, st3_pkg::ADDR_RLD_HI)) begin
            s_nxt.reload_high_byte = sfr_req.wdata;
        end
        if (sel_hit(sfr_req, st3_pkg::ADDR_CNT_LO)) begin
            s_nxt.count_low_byte = sfr_req.wdata;
        end
        if (sel_hit(sfr_req, st3_pkg::ADDR_CNT_HI)) begin
            s_nxt.count_high_byte = sfr_req.wdata;
        end
        if (sel_hit(sfr_req, st3_pkg::ADDR_CTRL)) begin
            // writing 1 to a flag sets it, 0 clears it
            s_nxt.ctrl         = sfr_req.wdata; // [R4] [R16]
            s_nxt.ctrl.unused  = 1'b0; // [R10]
        end

        // hardware set beats a same-cycle software clear
        if (set_hovf) begin
            s_nxt.ctrl.hovf = 1'b1; // [R1] [R4]
        end
        if (set_lovf) begin
            s_nxt.ctrl.lovf = 1'b1; // [R5] [R4]
        end

        // level request; flags stay set on interrupt entry
        s_nxt.irq = timer_irq_enable
                    && (s_nxt.ctrl.hovf // [R3]
                        || (s_nxt.ctrl.lirq_en && s_nxt.ctrl.lovf)); // [R6]

        // read data one cycle behind the address
        case (sfr_req.addr)
            st3_pkg::ADDR_CTRL: begin
                s_nxt.rdata = s_r.ctrl; // [R10]
            end
            st3_pkg::ADDR_RLD_LO: begin
                s_nxt.rdata = s_r.reload_low_byte;
            end
            st3_pkg::ADDR_RLD_HI: begin
                s_nxt.rdata = s_r.reload_high_byte;
            end
            st3_pkg::ADDR_CNT_LO: begin
                s_nxt.rdata = s_r.count_low_byte;
            end
            st3_pkg::ADDR_CNT_HI: begin
                s_nxt.rdata = s_r.count_high_byte;
            end
            default: begin
                s_nxt.rdata = st3_pkg::UNMAPPED_RD;
            end
        endcase
    end

    // =========================================================
    // registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r.ctrl             <= st3_pkg::CTRL_RESET;
            s_r.count_high_byte  <= st3_pkg::DATA_RESET;
            s_r.count_low_byte   <= st3_pkg::DATA_RESET;
            s_r.reload_high_byte <= st3_pkg::DATA_RESET;
            s_r.reload_low_byte  <= st3_pkg::DATA_RESET;
            s_r.rdata            <= st3_pkg::DATA_RESET;
            s_r.irq              <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // =========================================================
    // outputs, all straight from flops
    assign sfr_rdata   = s_r.rdata;
    assign irq_req     = s_r.irq;
    assign count_value = {s_r.count_high_byte, s_r.count_low_byte};

endmodule : st3_timer

// [dv/st3_timer_bench.sv]
module st3_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk, resetn, hsel, lsel, ien, ext, irq;
    st3_pkg::st3_sfr_req_s req;
    logic [7:0]            rdata;
    logic [15:0]           cnt;
    logic [3:0]            ediv;
    int                    n_fail, check_count, cyc;
    localparam logic [7:0] CT = st3_pkg::ADDR_CTRL;
    st3_timer u_st3_timer (
        .clk(clk), .resetn(resetn), .sfr_req(req), .sfr_rdata(rdata),
        .high_byte_clock_select(hsel), .low_byte_clock_select(lsel),
        .timer_irq_enable(ien), .ext_osc(ext), .irq_req(irq),
        .count_value(cnt));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // external oscillator at a quarter of clk, so ext/8 is 32 cycles
    always @(posedge clk) begin
        ediv <= ediv + 4'h1;
        ext  <= ediv[1];
        cyc  <= cyc + 1;
        // whole run needs well under a thousand cycles
        if (cyc == 2000) begin
            n_fail++;
            end_sim();
        end
    end
    // =========================================================
    // access tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wr: 1'b1, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req.addr <= a;
        repeat (2) @(posedge clk);
        #1;
        chk({8'h00, rdata}, {8'h00, exp});
    endtask : rdc
    task automatic wait_cnt(input logic [15:0] exp, input int lim);
        for (int i = 0; i < lim && cnt !== exp; i++) begin
            @(posedge clk);
            #1;
        end
        chk(cnt, exp);
    endtask : wait_cnt
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    // =========================================================
    // tests
    initial begin
        resetn = 1'b0;
        req = '0;
        {hsel, lsel, ien, ext, ediv, n_fail, check_count, cyc} = '0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        for (int a = 8'h90; a <= 8'h96; a++) rdc(8'(a), 8'h00);
        wr(CT, 8'h3A);
        rdc(CT, 8'h38);
        ien <= 1'b1;
        wr(CT, 8'hC0);
        repeat (20) @(posedge clk);
        rdc(CT, 8'hC0);
        chk({15'h0, irq}, 16'h0001);
        wr(CT, 8'h40);
        rdc(CT, 8'h40);
        chk({15'h0, irq}, 16'h0000);
        wr(CT, 8'h60);
        rdc(CT, 8'h60);
        chk({15'h0, irq}, 16'h0001);
        ien <= 1'b0;
        rdc(CT, 8'h60);
        chk({15'h0, irq}, 16'h0000);
        ien <= 1'b1;
        // undivided clock through a 16-bit wrap
        lsel <= 1'b1;
        wr(st3_pkg::ADDR_RLD_LO, 8'h34);
        wr(st3_pkg::ADDR_RLD_HI, 8'h12);
        wr(st3_pkg::ADDR_CNT_LO, 8'hFD);
        wr(st3_pkg::ADDR_CNT_HI, 8'hFF);
        wr(CT, 8'h04);
        wait_cnt(16'h1234, 8);
        rdc(CT, 8'hC4);
        rdc(st3_pkg::ADDR_RLD_LO, 8'h34);
        wr(CT, 8'h00);
        wr(st3_pkg::ADDR_CNT_LO, 8'h55);
        wr(st3_pkg::ADDR_CNT_HI, 8'h55);
        repeat (20) @(posedge clk);
        #1;
        chk(cnt, 16'h5555);
        // divided timebases, exact spacing
        lsel <= 1'b0;
        wr(CT, 8'h04);
        wait_cnt(16'h5556, 16);
        repeat (60) @(posedge clk);
        #1;
        chk(cnt, 16'h555B);
        wr(CT, 8'h01);
        wr(st3_pkg::ADDR_CNT_LO, 8'h00);
        wr(st3_pkg::ADDR_CNT_HI, 8'h00);
        wr(CT, 8'h05);
        wait_cnt(16'h0001, 40);
        repeat (64) @(posedge clk);
        #1;
        chk(cnt, 16'h0003);
        // split: low byte free running, high byte gated by run
        {lsel, hsel} <= 2'b11;
        wr(CT, 8'h28);
        wr(st3_pkg::ADDR_CNT_HI, 8'hFE);
        repeat (20) @(posedge clk);
        #1;
        chk({8'h00, cnt[15:8]}, 16'h00FE);
        chk({15'h0, irq}, 16'h0000);
        // low byte alone wraps once in this wait, high byte held
        repeat (240) @(posedge clk);
        rdc(CT, 8'h68);
        chk({15'h0, irq}, 16'h0001);
        wr(CT, 8'h0C);
        repeat (4) @(posedge clk);
        rdc(CT, 8'h8C);
        chk({15'h0, irq}, 16'h0001);
        // capture of a running count into reload
        hsel <= 1'b0;
        wr(CT, 8'h00);
        wr(st3_pkg::ADDR_RLD_HI, 8'h00);
        wr(st3_pkg::ADDR_CNT_HI, 8'h10);
        wr(st3_pkg::ADDR_CNT_LO, 8'h00);
        wr(CT, 8'h15);
        repeat (40) @(posedge clk);
        rdc(CT, 8'h95);
        rdc(st3_pkg::ADDR_RLD_HI, 8'h10);
        end_sim();
    end
endmodule : st3_timer_bench

// [dv/st3_timer_checker.sv]
module st3_timer_checker (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  resetn,
    // register port
    input wire st3_pkg::st3_sfr_req_s sfr_req,
    input wire logic [7:0]            sfr_rdata,
    // selects and status
    input wire logic                  low_byte_clock_select,
    input wire logic                  timer_irq_enable,
    input wire logic                  irq_req,
    input wire logic [15:0]           count_value
);
    // =========================================================
    // control shadow: lirq, cap, split, run change only by writes
    logic [3:0] ctl_r;
    logic       q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl_r <= 4'h0;
        end else if (sfr_req.wr && sfr_req.addr == st3_pkg::ADDR_CTRL) begin
            ctl_r <= sfr_req.wdata[5:2];
        end
    end
    assign q = !sfr_req.wr && low_byte_clock_select;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // =========================================================
    // properties
    AST_UNUSED_ZERO: assert property (
        sfr_req.addr == st3_pkg::ADDR_CTRL |=> !sfr_rdata[1])
        else $error("unused control bit read high");
    AST_STOPPED: assert property (
        !ctl_r[1] && !ctl_r[0] && !sfr_req.wr |=> $stable(count_value))
        else $error("stopped counter moved");
    AST_STEP16: assert property (
        !ctl_r[1] && ctl_r[0] && q && $past(low_byte_clock_select)
        && count_value != st3_pkg::WORD_MAX
        |=> count_value == $past(count_value) + 16'h0001)
        else $error("16-bit count did not step");
    AST_SPLIT_LOW: assert property (
        ctl_r[1] && q && $past(low_byte_clock_select)
        && count_value[7:0] != st3_pkg::BYTE_MAX
        |=> count_value[7:0] == $past(count_value[7:0]) + 8'h01)
        else $error("split low byte did not step");
    AST_SPLIT_HIGH: assert property (
        ctl_r[1] && !ctl_r[0] && !sfr_req.wr
        |=> $stable(count_value[15:8]))
        else $error("gated high byte moved");
    AST_IRQ_OFF: assert property (
        !timer_irq_enable |=> !irq_req)
        else $error("irq without enable");
    AST_WRAP_IRQ: assert property (
        !ctl_r[1] && ctl_r[0] && q && $past(low_byte_clock_select)
        && count_value == st3_pkg::WORD_MAX && timer_irq_enable
        |-> ##[1:2] irq_req)
        else $error("no irq after 16-bit wrap");
    AST_LOW_IRQ: assert property (
        ctl_r[1] && ctl_r[3] && q && $past(low_byte_clock_select)
        && count_value[7:0] == st3_pkg::BYTE_MAX && timer_irq_enable
        |-> ##[1:2] irq_req)
        else $error("no irq after low byte wrap");
    cover property (count_value == st3_pkg::WORD_MAX ##1 !ctl_r[1]);
    cover property (irq_req);
    cover property (ctl_r[1] && ctl_r[0]);
    cover property (ctl_r[1] && ctl_r[3] && irq_req);
endmodule : st3_timer_checker

bind st3_timer st3_timer_checker u_st3_timer_checker (
    .clk                   (clk),
    .resetn                (resetn),
    .sfr_req               (sfr_req),
    .sfr_rdata             (sfr_rdata),
    .low_byte_clock_select (low_byte_clock_select),
    .timer_irq_enable      (timer_irq_enable),
    .irq_req               (irq_req),
    .count_value           (count_value)
);
